// File: shared/srl_pkg.sv
// Constants shared by the set-reset latch unit: register map, field layout and timing.
// Assumes a 32-bit APB slave port; registers sit in the low bits of aligned words.
package srl_pkg;
  // Register byte addresses.
  localparam logic [7:0] SRL_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] SRL_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] SRL_ADDR_STATUS = 8'h08;
  localparam int SRL_ADDR_W = 8;
  // Control register 0 fields.
  localparam int SRL_C0_LATCH_EN = 7;
  localparam int SRL_C0_SEL_HI = 6;
  localparam int SRL_C0_SEL_LO = 4;
  localparam int SRL_C0_TRUE_EN = 3;
  localparam int SRL_C0_INV_EN = 2;
  localparam int SRL_C0_FW_SET = 1;
  localparam int SRL_C0_FW_RST = 0;
  localparam logic [7:0] SRL_CTRL0_RESET = 8'h00;
  // Control register 1 fields: per-source set and reset enables, then the comparator timer resampling bits.
  localparam int SRL_C1_PULSE_SET = 0;
  localparam int SRL_C1_PULSE_RST = 1;
  localparam int SRL_C1_EXT_SET = 2;
  localparam int SRL_C1_EXT_RST = 3;
  localparam int SRL_C1_CMP1_SET = 4;
  localparam int SRL_C1_CMP1_RST = 5;
  localparam int SRL_C1_CMP2_SET = 6;
  localparam int SRL_C1_CMP2_RST = 7;
  localparam int SRL_C1_CMP1_TSYNC = 8;
  localparam int SRL_C1_CMP2_TSYNC = 9;
  localparam int SRL_CTRL1_W = 10;
  localparam logic [SRL_CTRL1_W-1:0] SRL_CTRL1_RESET = 10'h000;
  // Status register field.
  localparam int SRL_ST_STATE = 0;
  // Periodic pulse divider: code 0 divides by 4, each code doubles it.
  localparam int SRL_DIV_BASE_LOG2 = 2;
  localparam int SRL_SEL_W = 3;
  localparam int SRL_DIV_CNT_W = 9;
  // System clock figures.
  localparam int SRL_CLOCK_HZ = 50_000_000;
  localparam int SRL_CLOCK_NS = 1_000_000_000 / SRL_CLOCK_HZ;
  // Firmware pulse lasts one instruction period, which is one system clock here.
  localparam int SRL_FW_PULSE_NS = 20;
  localparam int SRL_FW_PULSE_CYC = (SRL_FW_PULSE_NS + SRL_CLOCK_NS - 1) / SRL_CLOCK_NS;
endpackage

// File: verilog/srl_latch_unit.sv
// Set-reset latch unit with an APB register port and two gated latch output pins.
// Assumes comparator results and the external input are asynchronous, while the timer tick
// and the pin direction bits come from logic on the same clock.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none

module srl_latch_unit
(
  input wire logic clock, // System clock, 50 MHz.
  input wire logic rst_n, // Asynchronous active-low reset.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [srl_pkg::SRL_ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic comparator_one_result, // First comparator output, asynchronous.
  input wire logic comparator_two_result, // Second comparator output, asynchronous.
  input wire logic latch_external_input, // External latch input pin.
  input wire logic timer_tick, // One-cycle tick of the timer clock source.
  input wire logic true_pin_direction_bit, // Direction of true pin, low selects output.
  input wire logic inverted_pin_direction_bit, // Direction of inverted pin, low is output.
  output logic true_output_pin, // True latch output value.
  output logic true_output_pin_oe, // True pin output enable.
  output logic inverted_output_pin, // Inverted latch output value.
  output logic inverted_output_pin_oe // Inverted pin output enable.
);
  import srl_pkg::*;

  logic rst_meta_q;
  logic rst_sync_n;
  logic [7:0] ctrl0_q;
  logic [SRL_CTRL1_W-1:0] ctrl1_q;
  logic fw_set_q;
  logic fw_rst_q;
  logic [1:0] cmp1_sync_q;
  logic [1:0] cmp2_sync_q;
  logic [1:0] ext_sync_q;
  logic cmp1_timed_q;
  logic cmp2_timed_q;
  logic [SRL_DIV_CNT_W-1:0] div_cnt_q;
  logic [SRL_DIV_CNT_W-1:0] div_mask;
  logic pulse_q;
  logic latch_q;
  logic latch_d;
  logic set_eff;
  logic rst_eff;
  logic cmp1_src;
  logic cmp2_src;
  logic ext_src;
  logic latch_en;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_word;
  logic addr_ok;
  logic wr_ctrl0;

  // Reset is released through two flops so every register reset by it leaves reset on the same edge.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // Zero-wait APB slave: every access completes in its first access cycle. The read word is
  // picked in the setup cycle so that the answer can stand in flops during the access cycle.
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == SRL_ADDR_CTRL0) || (paddr == SRL_ADDR_CTRL1)
    || (paddr == SRL_ADDR_STATUS);
  assign wr_ctrl0 = wr_en && pstrb[0] && (paddr == SRL_ADDR_CTRL0);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (paddr == SRL_ADDR_CTRL0)
      rd_word = {24'h00_0000, ctrl0_q[7:2], fw_set_q, fw_rst_q};
    else if (paddr == SRL_ADDR_CTRL1)
      rd_word = {22'h00_0000, ctrl1_q};
    else if (paddr == SRL_ADDR_STATUS)
      rd_word = {31'h0000_0000, latch_q};
  end

  // Ready, error and read data are loaded in the setup cycle, so the bus pins carry no path
  // from the bus inputs; an unmapped word reads as zero with the error raised.
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= rd_en ? rd_word : 32'h0000_0000;
    end
  end

  // Control register 0 holds the steady fields; the two pulse bits live in their own flops.
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ctrl0_q <= SRL_CTRL0_RESET;
    else if (wr_ctrl0)
      ctrl0_q <= {pwdata[7:2], 2'b00};
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ctrl1_q <= SRL_CTRL1_RESET;
    else if (wr_en && (paddr == SRL_ADDR_CTRL1))
    begin
      if (pstrb[0])
        ctrl1_q[7:0] <= pwdata[7:0];
      if (pstrb[1])
        ctrl1_q[SRL_CTRL1_W-1:8] <= pwdata[SRL_CTRL1_W-1:8];
    end
  end

  // A written one raises the pulse for one clock, then it clears with no second write.
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fw_set_q <= 1'b0;
      fw_rst_q <= 1'b0;
    end
    else
    begin
      fw_set_q <= wr_ctrl0 && pwdata[SRL_C0_FW_SET];
      fw_rst_q <= wr_ctrl0 && pwdata[SRL_C0_FW_RST];
    end
  end

  // Asynchronous sources pass two flops before any logic reads them.
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cmp1_sync_q <= 2'b00;
      cmp2_sync_q <= 2'b00;
      ext_sync_q <= 2'b00;
    end
    else
    begin
      cmp1_sync_q <= {cmp1_sync_q[0], comparator_one_result};
      cmp2_sync_q <= {cmp2_sync_q[0], comparator_two_result};
      ext_sync_q <= {ext_sync_q[0], latch_external_input};
    end
  end

  // Optional resampling of each comparator result on the timer clock tick.
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cmp1_timed_q <= 1'b0;
      cmp2_timed_q <= 1'b0;
    end
    else if (timer_tick)
    begin
      cmp1_timed_q <= cmp1_sync_q[1];
      cmp2_timed_q <= cmp2_sync_q[1];
    end
  end

  assign cmp1_src = ctrl1_q[SRL_C1_CMP1_TSYNC] ? cmp1_timed_q : cmp1_sync_q[1];
  assign cmp2_src = ctrl1_q[SRL_C1_CMP2_TSYNC] ? cmp2_timed_q : cmp2_sync_q[1];
  assign ext_src = ext_sync_q[1];

  // Free-running divider; the mask keeps the low bits of the selected power of two.
  assign div_mask = SRL_DIV_CNT_W'((10'h001 << (SRL_DIV_BASE_LOG2
    + int'(ctrl0_q[SRL_C0_SEL_HI:SRL_C0_SEL_LO]))) - 10'h001);

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      div_cnt_q <= '0;
      pulse_q <= 1'b0;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + SRL_DIV_CNT_W'(1);
      pulse_q <= ((div_cnt_q & div_mask) == div_mask);
    end
  end

  assign latch_en = ctrl0_q[SRL_C0_LATCH_EN];

  // Every enabled source feeds its input; reset then dominates set.
  always_comb
  begin
    set_eff = fw_set_q
      || (pulse_q && ctrl1_q[SRL_C1_PULSE_SET])
      || (ext_src && ctrl1_q[SRL_C1_EXT_SET])
      || (cmp1_src && ctrl1_q[SRL_C1_CMP1_SET])
      || (cmp2_src && ctrl1_q[SRL_C1_CMP2_SET]);
    rst_eff = fw_rst_q
      || (pulse_q && ctrl1_q[SRL_C1_PULSE_RST])
      || (ext_src && ctrl1_q[SRL_C1_EXT_RST])
      || (cmp1_src && ctrl1_q[SRL_C1_CMP1_RST])
      || (cmp2_src && ctrl1_q[SRL_C1_CMP2_RST]);
    latch_d = latch_q;
    if (latch_en && rst_eff)
      latch_d = 1'b0;
    else if (latch_en && set_eff)
      latch_d = 1'b1;
  end

  // The latch holds its state across reset, so it starts unknown until software sets or resets it.
  always_ff @(posedge clock)
  begin
    latch_q <= latch_d;
  end

  // Each pin drives only with the latch enabled, its own enable set and its direction low.
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      true_output_pin <= 1'b0;
      true_output_pin_oe <= 1'b0;
      inverted_output_pin <= 1'b0;
      inverted_output_pin_oe <= 1'b0;
    end
    else
    begin
      true_output_pin_oe <= latch_en && ctrl0_q[SRL_C0_TRUE_EN]
        && !true_pin_direction_bit;
      inverted_output_pin_oe <= latch_en && ctrl0_q[SRL_C0_INV_EN]
        && !inverted_pin_direction_bit;
      true_output_pin <= latch_en && ctrl0_q[SRL_C0_TRUE_EN] && latch_d;
      inverted_output_pin <= latch_en && ctrl0_q[SRL_C0_INV_EN] && !latch_d;
    end
  end

  // Checks.
  sequence s_fw_set_write;
    wr_ctrl0 && pwdata[SRL_C0_FW_SET];
  endsequence

  sequence s_one_cycle_set;
    fw_set_q ##1 !fw_set_q;
  endsequence

  sequence s_fw_rst_write;
    wr_ctrl0 && pwdata[SRL_C0_FW_RST];
  endsequence

  sequence s_one_cycle_rst;
    fw_rst_q ##1 !fw_rst_q;
  endsequence

  sequence s_sel0_quiet;
    !wr_ctrl0 && (ctrl0_q[SRL_C0_SEL_HI:SRL_C0_SEL_LO] == 3'b000);
  endsequence

  a_reset_dominates: assert property (@(posedge clock) disable iff (!rst_sync_n)
    latch_en && set_eff && rst_eff |=> !latch_q)
    else $error("Latch did not take reset with set and reset both high.");

  a_set_takes_latch: assert property (@(posedge clock) disable iff (!rst_sync_n)
    latch_en && set_eff && !rst_eff |=> latch_q)
    else $error("Enabled set source did not set the latch.");

  a_fw_pulse_once: assert property (@(posedge clock) disable iff (!rst_sync_n)
    s_fw_set_write |=> s_one_cycle_set)
    else $error("Firmware set pulse was not exactly one cycle wide.");

  a_fw_zero_noop: assert property (@(posedge clock) disable iff (!rst_sync_n)
    wr_ctrl0 && !pwdata[SRL_C0_FW_RST] |=> !fw_rst_q)
    else $error("Writing zero raised the firmware reset pulse.");

  a_pulse_width: assert property (@(posedge clock) disable iff (!rst_sync_n)
    s_sel0_quiet and pulse_q |=> !pulse_q)
    else $error("Periodic pulse was wider than one clock.");

  a_pulse_period: assert property (@(posedge clock) disable iff (!rst_sync_n)
    pulse_q ##0 s_sel0_quiet[*4] |=> pulse_q)
    else $error("Periodic pulse did not repeat every four clocks.");

  a_pulse_path: assert property (@(posedge clock) disable iff (!rst_sync_n)
    latch_en && pulse_q && ctrl1_q[SRL_C1_PULSE_RST] |=> !latch_q)
    else $error("Enabled periodic pulse did not reset the latch.");

  a_pin_gating: assert property (@(posedge clock) disable iff (!rst_sync_n)
    true_output_pin_oe |-> $past(latch_en && ctrl0_q[SRL_C0_TRUE_EN]
      && !true_pin_direction_bit))
    else $error("True pin drove without enable or with direction set to input.");

  a_disabled_quiet: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !latch_en ##1 !latch_en |-> !true_output_pin_oe && !inverted_output_pin_oe)
    else $error("A pin drove while the latch was disabled.");

  a_both_pins: assert property (@(posedge clock) disable iff (!rst_sync_n)
    true_output_pin_oe && inverted_output_pin_oe |-> true_output_pin != inverted_output_pin)
    else $error("True and inverted pins were not complementary.");

  a_zero_wait: assert property (@(posedge clock) disable iff (!rst_sync_n)
    psel && !penable |=> pready)
    else $error("Slave did not answer in the first access cycle.");

  a_fw_reset_once: assert property (@(posedge clock) disable iff (!rst_sync_n)
    s_fw_rst_write |=> s_one_cycle_rst)
    else $error("Firmware reset pulse was not exactly one cycle wide.");

  a_disabled_frozen: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !latch_en && latch_q |=> latch_q)
    else $error("Latch left the set state while disabled.");

  a_ready_access: assert property (@(posedge clock) disable iff (!rst_sync_n)
    pready |-> psel && penable)
    else $error("Ready was raised outside an access cycle.");
endmodule

`default_nettype wire

// File: sim/srl_latch_unit_tb.sv
// Self-checking bench for the set-reset latch unit, driving APB and all source pins.
// Assumes zero-wait APB reads and a latch state that survives reset.
`timescale 1ns/1ns
`default_nettype none
module srl_latch_unit_tb;
  import srl_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic cmp1 = 1'b0, cmp2 = 1'b0, ext_in = 1'b0, timer_tick = 1'b0;
  logic dir_t = 1'b0, dir_i = 1'b0, pin_chk = 1'b0;
  logic q_pin, q_oe, nq_pin, nq_oe;
  logic [32:0] rd_q[$];
  logic [7:0] pin_q[$];
  logic [32:0] rexp;
  logic [7:0] pexp;
  int bad_count = 0, checks = 0, cyc = 0, t1, t2;
  always #10 clock = ~clock;
  srl_latch_unit dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_one_result(cmp1),
    .comparator_two_result(cmp2), .latch_external_input(ext_in), .timer_tick(timer_tick),
    .true_pin_direction_bit(dir_t), .inverted_pin_direction_bit(dir_i),
    .true_output_pin(q_pin), .true_output_pin_oe(q_oe), .inverted_output_pin(nq_pin),
    .inverted_output_pin_oe(nq_oe));
  task automatic miss(input logic [32:0] e, input logic [32:0] g);
    bad_count++;
    $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
  endtask
  task automatic conclude();
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Random ticks make the timer resampling path see irregular spacing.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    timer_tick <= 1'($urandom % 2);
  end
  // Watches read data and pin samples, pairing each with the oldest note.
  always @(posedge clock)
  begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0)
    begin
      rexp = rd_q.pop_front();
      checks++;
      if ({pslverr, prdata} !== rexp)
        miss(rexp, {pslverr, prdata});
    end
    if (pin_chk && pin_q.size() > 0)
    begin
      pexp = pin_q.pop_front();
      checks++;
      if (({q_oe, q_pin, nq_oe, nq_pin} & pexp[7:4]) !== (pexp[3:0] & pexp[7:4]))
        miss({29'h0, pexp[3:0]}, {29'h0, q_oe, q_pin, nq_oe, nq_pin});
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      rd_q.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      miss(33'h1, 33'h0);
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0000_0000, {1'b0, d});
  endtask
  task automatic pins(input logic [3:0] e, input logic [3:0] m);
    pin_q.push_back({m, e});
    pin_chk <= 1'b1;
    @(posedge clock);
    pin_chk <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_q(input logic v, output int t);
    int n;
    for (n = 0; n < 600 && q_pin !== v; n++)
      @(posedge clock);
    if (n >= 600)
    begin
      miss({32'h0, v}, {32'h0, q_pin});
      conclude();
    end
    t = cyc;
  endtask
  initial
  begin
    logic [31:0] r;
    void'($urandom(32'h0000_88ee));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(SRL_ADDR_CTRL0, 32'h0000_0000);
    rd(SRL_ADDR_CTRL1, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000, {1'b1, 32'h0000_0000});
    wr(8'h10, 32'hffff_ffff);
    rd(SRL_ADDR_CTRL0, 32'h0000_0000);
    repeat (4)
    begin
      r = $urandom & 32'h0000_00ff;
      wr(SRL_ADDR_CTRL0, r);
      rd(SRL_ADDR_CTRL0, r & 32'h0000_00fc);
    end
    wr(SRL_ADDR_CTRL1, 32'h0000_0000);
    wr(SRL_ADDR_CTRL0, 32'h0000_0082);
    rd(SRL_ADDR_STATUS, 32'h0000_0001);
    wr(SRL_ADDR_CTRL0, 32'h0000_0080);
    rd(SRL_ADDR_STATUS, 32'h0000_0001);
    wr(SRL_ADDR_CTRL0, 32'h0000_0083);
    rd(SRL_ADDR_STATUS, 32'h0000_0000);
    wr(SRL_ADDR_CTRL0, 32'h0000_0082);
    wr(SRL_ADDR_CTRL0, 32'h0000_008c);
    repeat (3) @(posedge clock);
    pins(4'b1110, 4'b1111);
    dir_t <= 1'b1;
    repeat (3) @(posedge clock);
    pins(4'b0010, 4'b1010);
    dir_t <= 1'b0;
    wr(SRL_ADDR_CTRL0, 32'h0000_0088);
    repeat (3) @(posedge clock);
    pins(4'b1100, 4'b1110);
    wr(SRL_ADDR_CTRL0, 32'h0000_000d);
    repeat (3) @(posedge clock);
    pins(4'b0000, 4'b1010);
    rd(SRL_ADDR_STATUS, 32'h0000_0001);
    wr(SRL_ADDR_CTRL0, 32'h0000_0080);
    wr(SRL_ADDR_CTRL1, 32'h0000_0004);
    ext_in <= 1'b1;
    repeat (6) @(posedge clock);
    rd(SRL_ADDR_STATUS, 32'h0000_0001);
    wr(SRL_ADDR_CTRL1, 32'h0000_000c);
    repeat (6) @(posedge clock);
    rd(SRL_ADDR_STATUS, 32'h0000_0000);
    ext_in <= 1'b0;
    // Bit 0 picks timer resampling, bit 1 swaps which comparator sets and which resets.
    for (int k = 0; k < 4; k++)
    begin
      wr(SRL_ADDR_CTRL1, (k[0] ? 32'h0000_0300 : 32'h0000_0000)
        | (k[1] ? 32'h0000_0060 : 32'h0000_0090));
      {cmp2, cmp1} <= k[1] ? 2'b10 : 2'b01;
      repeat (20) @(posedge clock);
      rd(SRL_ADDR_STATUS, 32'h0000_0001);
      {cmp2, cmp1} <= k[1] ? 2'b01 : 2'b10;
      repeat (20) @(posedge clock);
      rd(SRL_ADDR_STATUS, 32'h0000_0000);
      {cmp2, cmp1} <= 2'b00;
    end
    // Set the latch before the pulse may reset it, so the set never races a pulse.
    wr(SRL_ADDR_CTRL1, 32'h0000_0000);
    wr(SRL_ADDR_CTRL0, 32'h0000_008a);
    wait_q(1'b1, t1);
    wr(SRL_ADDR_CTRL1, 32'h0000_0002);
    wait_q(1'b0, t1);
    wr(SRL_ADDR_CTRL1, 32'h0000_0001);
    for (int s = 0; s < 8; s++)
    begin
      wr(SRL_ADDR_CTRL0, 32'h0000_0089 | (s << 4));
      wait_q(1'b0, t1);
      wait_q(1'b1, t1);
      wr(SRL_ADDR_CTRL0, 32'h0000_0089 | (s << 4));
      wait_q(1'b0, t2);
      wait_q(1'b1, t2);
      checks++;
      if ((t2 - t1) % (4 << s) != 0)
        miss(33'(4 << s), 33'(t2 - t1));
    end
    wr(SRL_ADDR_CTRL1, 32'h0000_0000);
    wr(SRL_ADDR_CTRL0, 32'h0000_0082);
    repeat (2) @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(SRL_ADDR_CTRL0, 32'h0000_0000);
    rd(SRL_ADDR_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clock);
    conclude();
  end
endmodule
`default_nettype wire
